// ===== verilog/fwgsp_host.sv
// Purpose: Host controller driving the flash pins for reads, writes and sector protect modes
// Assumes: Flash data pins are two-way; high-voltage levels are switched by external drivers
// Notes: One request at a time; req_ready_o low while busy
// Overview of operation
// - Host holds chip select and write strobe low, output enable high, to write.
// - Protect: high voltage on bit nine and output enable over a strobe pulse.
// - Unprotect: high voltage on output enable and bit nine, bit six high, pulse.
// - Protecting all sectors before chip unprotect is recommended only.
`timescale 1ns/1ps
module fwgsp_host (
    input wire logic clk_sys_i, // System clock 20 MHz
    input wire logic reset_n_i, // Async reset, active low
    input wire fwgsp_pkg::fwgsp_req_s req_i, // Request
    input wire logic req_valid_i, // Request strobe
    output logic req_ready_o, // Idle and able to take a request
    output logic done_o, // One-cycle pulse at completion
    output logic [7:0] rd_data_o, // Read result
    output logic protected_o, // Verify result, sector protected
    output logic sleep_hint_o, // Address steady long enough for sleep
    output fwgsp_pkg::fwgsp_pins_s pins_o, // Flash pin drive
    input wire logic [7:0] flash_data_i // Flash data pins in
);
    typedef enum logic [2:0] {
        FWGSP_ST_IDLE,
        FWGSP_ST_SETUP,
        FWGSP_ST_LOW,
        FWGSP_ST_HIGH,
        FWGSP_ST_READ,
        FWGSP_ST_DONE
    } fwgsp_state_e;

    typedef struct packed {
        fwgsp_state_e st;
        fwgsp_pkg::fwgsp_req_s req;
        logic [1:0] seq;
        logic [fwgsp_pkg::CNT_W-1:0] cnt;
        logic [fwgsp_pkg::CNT_W-1:0] steady;
        logic ready;
        logic done;
        logic [7:0] rd_data;
        logic prot;
        logic sleep;
        fwgsp_pkg::fwgsp_pins_s pins;
    } fwgsp_state_s;

    localparam logic [7:0] WP_LOW = 8'(fwgsp_pkg::WP_LOW_CYC);
    localparam logic [7:0] WP_HIGH = 8'(fwgsp_pkg::WP_HIGH_CYC);
    localparam logic [7:0] RD_CYC = 8'(fwgsp_pkg::READ_CYC);
    localparam logic [7:0] SLEEP_C = 8'(fwgsp_pkg::SLEEP_CYC);

    fwgsp_state_s s_reg;
    fwgsp_state_s s_next;
    logic [7:0] data_sync;

    // Data pins cross into the clock domain
    fwgsp_sync #(.WIDTH(8)) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .async_i(flash_data_i),
        .sync_o(data_sync)
    );

    // Idle pin levels: nothing selected, no high voltage
    function automatic fwgsp_pkg::fwgsp_pins_s idle_pins(input logic [18:0] a);
        fwgsp_pkg::fwgsp_pins_s p;
        p = '0;
        p.chip_sel_n = 1'b1;
        p.write_strobe_n = 1'b1;
        p.out_en_n = 1'b1;
        p.data_oe_n = 1'b1;
        p.addr = a;
        return p;
    endfunction

    // Address and data of each step of the identification command sequence
    function automatic logic [26:0] id_step(input logic [1:0] n);
        case (n)
            2'h0: id_step = {fwgsp_pkg::UNLOCK_ADDR_A, fwgsp_pkg::CMD_AA};
            2'h1: id_step = {fwgsp_pkg::UNLOCK_ADDR_B, fwgsp_pkg::CMD_55};
            default: id_step = {fwgsp_pkg::UNLOCK_ADDR_A, fwgsp_pkg::CMD_IDREAD};
        endcase
    endfunction

    // Next state logic
    always_comb begin
        logic is_write;
        logic is_hv;
        logic [26:0] step;
        is_write = 1'b0;
        is_hv = 1'b0;
        step = '0;
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.cnt = s_reg.cnt + 8'h01;
        is_write = (s_reg.req.op == fwgsp_pkg::FWGSP_OP_WRITE) ||
            ((s_reg.req.op == fwgsp_pkg::FWGSP_OP_ID_CHECK) && (s_reg.seq != 2'h3));
        is_hv = (s_reg.req.op == fwgsp_pkg::FWGSP_OP_PROTECT) ||
            (s_reg.req.op == fwgsp_pkg::FWGSP_OP_UNPROTECT);
        step = id_step(s_reg.seq);
        case (s_reg.st)
            FWGSP_ST_IDLE: begin
                s_next.pins = idle_pins(s_reg.pins.addr);
                s_next.ready = 1'b1;
                if (req_valid_i) begin
                    s_next.req = req_i;
                    s_next.seq = 2'h0;
                    s_next.ready = 1'b0;
                    s_next.st = FWGSP_ST_SETUP;
                end
            end
            FWGSP_ST_SETUP: begin
                s_next.cnt = '0;
                s_next.pins = idle_pins(s_reg.req.addr);
                s_next.st = FWGSP_ST_LOW;
                case (s_reg.req.op)
                    fwgsp_pkg::FWGSP_OP_PROTECT: begin
                        s_next.pins.high_voltage_level_addr_bit_nine = 1'b1;
                        s_next.pins.high_voltage_level_oe_pin = 1'b1;
                        s_next.pins.chip_sel_n = 1'b0;
                    end
                    fwgsp_pkg::FWGSP_OP_UNPROTECT: begin
                        s_next.pins.high_voltage_level_addr_bit_nine = 1'b1;
                        s_next.pins.high_voltage_level_oe_pin = 1'b1;
                        s_next.pins.chip_sel_n = 1'b0;
                        s_next.pins.addr[fwgsp_pkg::ADDR_BIT_SIX] = 1'b1;
                    end
                    fwgsp_pkg::FWGSP_OP_VERIFY: begin
                        s_next.pins.high_voltage_level_addr_bit_nine = 1'b1;
                        s_next.pins.addr[fwgsp_pkg::ADDR_BIT_ONE] = 1'b1;
                        s_next.pins.addr[fwgsp_pkg::ADDR_BIT_ZERO] = 1'b0;
                        s_next.pins.addr[fwgsp_pkg::ADDR_BIT_SIX] = 1'b0;
                        s_next.st = FWGSP_ST_READ;
                    end
                    fwgsp_pkg::FWGSP_OP_READ: s_next.st = FWGSP_ST_READ;
                    fwgsp_pkg::FWGSP_OP_ID_CHECK: begin
                        if (s_reg.seq == 2'h3) begin
                            // sector read with bit one high
                            s_next.pins.addr[fwgsp_pkg::ADDR_BIT_ONE] = 1'b1;
                            s_next.st = FWGSP_ST_READ;
                        end else begin
                            s_next.pins.addr = step[26:8];
                            s_next.pins.data_out = step[7:0];
                            s_next.pins.data_oe_n = 1'b0;
                        end
                    end
                    default: begin
                        s_next.pins.data_out = s_reg.req.data;
                        s_next.pins.data_oe_n = 1'b0;
                    end
                endcase
                if (is_write) begin
                    // chip select low, output enable high
                    s_next.pins.chip_sel_n = 1'b0;
                    s_next.pins.out_en_n = 1'b1;
                end
            end
            FWGSP_ST_LOW: begin
                // pulse far longer than glitch window
                // strobe low only with output enable high
                s_next.pins.write_strobe_n = 1'b0;
                if (s_reg.cnt >= WP_LOW) begin
                    s_next.cnt = '0;
                    s_next.st = FWGSP_ST_HIGH;
                end
            end
            FWGSP_ST_HIGH: begin
                // Rising edge ends protect or unprotect pulse
                s_next.pins.write_strobe_n = 1'b1;
                if (s_reg.cnt >= WP_HIGH) begin
                    s_next.pins = idle_pins(s_reg.req.addr);
                    if ((s_reg.req.op == fwgsp_pkg::FWGSP_OP_ID_CHECK) && !is_hv) begin
                        s_next.seq = s_reg.seq + 2'h1;
                        s_next.st = FWGSP_ST_SETUP;
                    end else begin
                        s_next.st = FWGSP_ST_DONE;
                    end
                end
            end
            FWGSP_ST_READ: begin
                s_next.pins.chip_sel_n = 1'b0;
                s_next.pins.out_en_n = 1'b0;
                if (s_reg.cnt >= RD_CYC) begin
                    s_next.rd_data = data_sync;
                    s_next.prot = (data_sync != fwgsp_pkg::NOT_PROTECTED) && data_sync[0];
                    s_next.pins = idle_pins(s_reg.req.addr);
                    s_next.st = FWGSP_ST_DONE;
                end
            end
            FWGSP_ST_DONE: begin
                s_next.done = 1'b1;
                s_next.ready = 1'b1;
                if (s_reg.req.op == fwgsp_pkg::FWGSP_OP_ID_CHECK) begin
                    // Leave identification mode so later reads return array data
                    s_next.req.op = fwgsp_pkg::FWGSP_OP_WRITE;
                    s_next.req.data = fwgsp_pkg::CMD_RESET;
                    s_next.done = 1'b0;
                    s_next.ready = 1'b0;
                    s_next.st = FWGSP_ST_SETUP;
                end else begin
                    s_next.st = FWGSP_ST_IDLE;
                end
            end
            default: s_next.st = FWGSP_ST_IDLE;
        endcase
        // address steadiness count for sleep hint
        if (s_next.pins.addr != s_reg.pins.addr) begin
            s_next.steady = '0;
        end else if (s_reg.steady < SLEEP_C) begin
            s_next.steady = s_reg.steady + 8'h01;
        end
        s_next.sleep = (s_next.steady >= SLEEP_C);
    end

    // State register; reset leaves pins idle and high voltage off
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
            s_reg.pins.chip_sel_n <= 1'b1;
            s_reg.pins.write_strobe_n <= 1'b1;
            s_reg.pins.out_en_n <= 1'b1;
            s_reg.pins.data_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_ready_o = s_reg.ready;
    assign done_o = s_reg.done;
    assign rd_data_o = s_reg.rd_data;
    assign protected_o = s_reg.prot;
    assign sleep_hint_o = s_reg.sleep;
    assign pins_o = s_reg.pins;
endmodule

// ===== verilog/fwgsp_pkg.sv
// Purpose: Shared constants and carriers for the flash protect host controller
// Assumes: 20 MHz system clock, byte-wide flash with 19 address bits
// Notes: Timing counts derive from ns figures and the clock period
package fwgsp_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // Write pulse width low and high, access time and sleep margin in ns
    localparam int WP_LOW_NS = 35;
    localparam int WP_HIGH_NS = 30;
    localparam int GLITCH_NS = 5;
    localparam int ACCESS_TIME_NS = 70;
    localparam int SLEEP_MARGIN_NS = 30;
    // Least times round up, never below one cycle
    localparam int WP_LOW_CYC = (WP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_HIGH_CYC = (WP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int SLEEP_CYC = (ACCESS_TIME_NS + SLEEP_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // Address bit positions used by the high-voltage modes
    localparam int ADDR_BIT_ZERO = 0;
    localparam int ADDR_BIT_ONE = 1;
    localparam int ADDR_BIT_SIX = 6;
    localparam logic [7:0] NOT_PROTECTED = 8'h00;
    localparam logic [7:0] CMD_AA = 8'hAA;
    localparam logic [7:0] CMD_55 = 8'h55;
    localparam logic [7:0] CMD_IDREAD = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 19'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 19'h002AA;

    typedef enum logic [2:0] {
        FWGSP_OP_READ,
        FWGSP_OP_WRITE,
        FWGSP_OP_PROTECT,
        FWGSP_OP_VERIFY,
        FWGSP_OP_UNPROTECT,
        FWGSP_OP_ID_CHECK
    } fwgsp_op_e;

    // Request from the user side
    typedef struct packed {
        fwgsp_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fwgsp_req_s;

    // Pins driven toward the flash
    typedef struct packed {
        logic chip_sel_n;
        logic write_strobe_n;
        logic out_en_n;
        logic high_voltage_level_oe_pin;
        logic high_voltage_level_addr_bit_nine;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_out;
        logic data_oe_n;
    } fwgsp_pins_s;
endpackage

// ===== verilog/fwgsp_sync.sv
// Purpose: Two flip-flop synchroniser for a bus of flash pin inputs
// Assumes: Inputs are asynchronous to clk_sys_i
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module fwgsp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_i, // System clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic [WIDTH-1:0] async_i, // Pin level
    output logic [WIDTH-1:0] sync_o // Synchronised level
);
    logic [WIDTH-1:0] meta_reg;

    // Two stage capture
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule

// ===== sim/fwgsp_host_properties.sv
// Purpose: Pin-level checks on the flash protect host controller
// Assumes: One clock domain, reset active low
// Notes: Sees only the host ports; attached by bind
`timescale 1ns/1ps
module fwgsp_host_properties (
    input wire logic clk_sys_i, // System clock
    input wire logic reset_n_i, // Async reset, active low
    input wire fwgsp_pkg::fwgsp_req_s req_i, // Request
    input wire logic req_valid_i, // Request strobe
    input wire logic req_ready_o, // Idle
    input wire logic done_o, // Completion pulse
    input wire logic [7:0] rd_data_o, // Read result
    input wire logic protected_o, // Verify result
    input wire logic sleep_hint_o, // Sleep estimate
    input wire fwgsp_pkg::fwgsp_pins_s pins_o, // Flash pins
    input wire logic [7:0] flash_data_i // Flash data
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // Strobe pins against selects and qualifiers
    a_strobe_needs_select: assert property (!pins_o.write_strobe_n |-> !pins_o.chip_sel_n)
        else $error("write strobe low without chip select");
    a_write_oe_high: assert property ((!pins_o.write_strobe_n && !pins_o.high_voltage_level_oe_pin)
        |-> pins_o.out_en_n) else $error("logic write with output enable low");
    a_hv_pair: assert property ((pins_o.high_voltage_level_oe_pin && !pins_o.write_strobe_n)
        |-> pins_o.high_voltage_level_addr_bit_nine) else $error("high voltage on enable alone");
    a_hv_held: assert property ((!pins_o.write_strobe_n && pins_o.high_voltage_level_addr_bit_nine)
        |=> (pins_o.high_voltage_level_addr_bit_nine || pins_o.write_strobe_n)) else $error("qualifier dropped");
    a_pulse_bounded: assert property ($fell(pins_o.write_strobe_n) |-> ##[1:4] $rose(pins_o.write_strobe_n))
        else $error("write pulse too long");
    // Verify mode address pattern; the host must never fight the device on reads
    a_verify_addr: assert property ((pins_o.high_voltage_level_addr_bit_nine && !pins_o.chip_sel_n
        && !pins_o.out_en_n && !pins_o.high_voltage_level_oe_pin) |-> (pins_o.addr[1] && !pins_o.addr[0]
        && !pins_o.addr[6])) else $error("verify address bits wrong");
    a_no_contention: assert property ((!pins_o.out_en_n && !pins_o.high_voltage_level_oe_pin)
        |-> pins_o.data_oe_n) else $error("host drives data during read");
    // Handshake and sleep estimate
    a_take_busy: assert property ((req_valid_i && req_ready_o) |=> !req_ready_o)
        else $error("ready stayed high after take");
    a_done_single: assert property (done_o |-> req_ready_o ##1 !done_o)
        else $error("done not a single idle pulse");
    a_sleep_hint: assert property (($stable(pins_o.addr))[*5] |-> sleep_hint_o)
        else $error("sleep hint missing on steady address");
endmodule
bind fwgsp_host fwgsp_host_properties u_fwgsp_host_properties (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .rd_data_o(rd_data_o), .protected_o(protected_o), .sleep_hint_o(sleep_hint_o), .pins_o(pins_o),
    .flash_data_i(flash_data_i));

// ===== sim/fwgsp_flash_model.sv
// Purpose: Behavioural byte-wide flash with sector protection
// Assumes: Eight sectors on the top address bits; small memory window
// Notes: Released data pins show the inverse of what a read would give
`timescale 1ns/1ps
module fwgsp_flash_model #(
    parameter logic [7:0] PROG_CMD = 8'hA0, // Program opcode, plain default
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hC3 // Arbitrary value
) (
    input wire fwgsp_pkg::fwgsp_pins_s pins_i, // Host pin drive
    output logic [7:0] dq_o, // Data pins toward host
    output logic sleep_o // Device asleep
);
    logic [7:0] mem [0:255];
    logic [7:0] prot_reg = 8'h00;
    logic [1:0] seq_reg = 2'd0;
    logic id_reg = 1'b0;
    logic [7:0] rd;
    logic [7:0] d;
    logic [7:0] idx;
    logic [2:0] sec;
    realtime fall_t = 0.0;
    realtime addr_t = 0.0;
    assign sec = pins_i.addr[18:16];
    assign idx = {sec, pins_i.addr[4:0]};
    assign d = pins_i.data_out;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // glitch filter timestamps the strobe fall
    always @(negedge pins_i.write_strobe_n) fall_t = $realtime;
    always @(posedge pins_i.write_strobe_n) begin
        if (pins_i.chip_sel_n === 1'b0 && $realtime - fall_t >= fwgsp_pkg::GLITCH_NS) begin
            if (pins_i.high_voltage_level_oe_pin && pins_i.high_voltage_level_addr_bit_nine) begin
                if (pins_i.addr[6]) prot_reg = 8'h00;
                else prot_reg[sec] = 1'b1;
            end else if (pins_i.out_en_n === 1'b1) begin
                if (d == fwgsp_pkg::CMD_RESET) begin
                    seq_reg = 2'd0;
                    id_reg = 1'b0;
                end else if (seq_reg == 2'd3) begin
                    if (!prot_reg[sec]) mem[idx] = mem[idx] & d;
                    seq_reg = 2'd0;
                end else if (seq_reg == 2'd0 && pins_i.addr == fwgsp_pkg::UNLOCK_ADDR_A && d == fwgsp_pkg::CMD_AA)
                    seq_reg = 2'd1;
                else if (seq_reg == 2'd1 && pins_i.addr == fwgsp_pkg::UNLOCK_ADDR_B && d == fwgsp_pkg::CMD_55)
                    seq_reg = 2'd2;
                else if (seq_reg == 2'd2 && d == fwgsp_pkg::CMD_IDREAD) begin
                    id_reg = 1'b1;
                    seq_reg = 2'd0;
                end else seq_reg = (seq_reg == 2'd2 && d == PROG_CMD) ? 2'd3 : 2'd0;
            end
        end
    end
    // read path, addr bit one then bit zero pick the byte in id modes
    always @* begin
        if (pins_i.addr[1]) rd = {7'h00, prot_reg[sec]};
        else rd = pins_i.addr[0] ? DEVICE_CODE : MAKER_CODE;
        if (!(pins_i.high_voltage_level_addr_bit_nine || id_reg)) rd = mem[idx];
        if (pins_i.chip_sel_n === 1'b0 && pins_i.out_en_n === 1'b0 && pins_i.write_strobe_n === 1'b1) dq_o = rd;
        else dq_o = ~rd;
    end
    always @(pins_i.addr) addr_t = $realtime;
    always begin
        #5;
        sleep_o = ($realtime - addr_t) >= (fwgsp_pkg::ACCESS_TIME_NS + fwgsp_pkg::SLEEP_MARGIN_NS);
    end
endmodule

// ===== sim/test_fwgsp_host.sv
// Purpose: Self-checking bench for the flash protect host controller
// Assumes: Flash model on the pins; inputs change at falling edges
// Notes: Program opcode is a bench choice shared with the model
`timescale 1ns/1ps
module test_fwgsp_host;
    localparam logic [7:0] PROG_CMD = 8'hA0;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    fwgsp_pkg::fwgsp_req_s req_i = '0;
    logic req_valid_i = 1'b0;
    logic req_ready_o, done_o, protected_o, sleep_hint_o, dev_sleep;
    logic [7:0] rd_data_o, dq, flash_data_i;
    fwgsp_pkg::fwgsp_pins_s pins_o;
    int errors = 0;
    int cmp_count = 0;
    fwgsp_host u_fwgsp_host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .done_o(done_o), .rd_data_o(rd_data_o),
        .protected_o(protected_o), .sleep_hint_o(sleep_hint_o), .pins_o(pins_o), .flash_data_i(flash_data_i));
    fwgsp_flash_model #(.PROG_CMD(PROG_CMD)) u_fwgsp_flash_model (.pins_i(pins_o), .dq_o(dq), .sleep_o(dev_sleep));
    // Host drive wins only while it enables its data pins
    assign flash_data_i = pins_o.data_oe_n ? dq : pins_o.data_out;
    // 20 MHz clock
    initial forever #25 clk_sys_i = ~clk_sys_i;
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One request: hold valid across the taking edge, then wait for done under a bound
    task automatic do_op(input fwgsp_pkg::fwgsp_op_e op, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        req_i = '{op: op, addr: a, data: d};
        req_valid_i = 1'b1;
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("done_o", 8'h01, {7'h00, done_o});
    endtask
    task automatic prog(input logic [18:0] a, input logic [7:0] d);
        do_op(fwgsp_pkg::FWGSP_OP_WRITE, fwgsp_pkg::UNLOCK_ADDR_A, fwgsp_pkg::CMD_AA);
        do_op(fwgsp_pkg::FWGSP_OP_WRITE, fwgsp_pkg::UNLOCK_ADDR_B, fwgsp_pkg::CMD_55);
        do_op(fwgsp_pkg::FWGSP_OP_WRITE, fwgsp_pkg::UNLOCK_ADDR_A, PROG_CMD);
        do_op(fwgsp_pkg::FWGSP_OP_WRITE, a, d);
    endtask
    task automatic rd(input fwgsp_pkg::fwgsp_op_e op, input logic [18:0] a, input logic [7:0] exp);
        do_op(op, a, 8'h00);
        chk("rd_data_o", exp, rd_data_o);
    endtask
    // Idle strobes, erased array, stray writes change nothing
    task automatic t_power_up();
        chk("write_strobe_n", 8'h01, {7'h00, pins_o.write_strobe_n});
        chk("req_ready_o", 8'h01, {7'h00, req_ready_o});
        rd(fwgsp_pkg::FWGSP_OP_READ, 19'h00010, 8'hFF);
        do_op(fwgsp_pkg::FWGSP_OP_WRITE, 19'h00010, 8'h00);
        rd(fwgsp_pkg::FWGSP_OP_READ, 19'h00010, 8'hFF);
        prog(19'h00010, 8'h3C);
        rd(fwgsp_pkg::FWGSP_OP_READ, 19'h00010, 8'h3C);
    endtask
    // Protect one sector, verify both kinds, program is blocked
    task automatic t_protect();
        do_op(fwgsp_pkg::FWGSP_OP_PROTECT, 19'h10000, 8'h00);
        rd(fwgsp_pkg::FWGSP_OP_VERIFY, 19'h10000, 8'h01);
        chk("protected_o", 8'h01, {7'h00, protected_o});
        rd(fwgsp_pkg::FWGSP_OP_VERIFY, 19'h20000, 8'h00);
        chk("protected_o", 8'h00, {7'h00, protected_o});
        rd(fwgsp_pkg::FWGSP_OP_VERIFY, 19'h1FFFD, 8'h01);
        prog(19'h10010, 8'h3C);
        rd(fwgsp_pkg::FWGSP_OP_READ, 19'h10010, 8'hFF);
        rd(fwgsp_pkg::FWGSP_OP_ID_CHECK, 19'h10002, 8'h01);
        rd(fwgsp_pkg::FWGSP_OP_READ, 19'h00010, 8'h3C);
    endtask
    // Chip unprotect clears every sector
    task automatic t_unprotect();
        do_op(fwgsp_pkg::FWGSP_OP_PROTECT, 19'h30000, 8'h00);
        do_op(fwgsp_pkg::FWGSP_OP_UNPROTECT, 19'h00000, 8'h00);
        rd(fwgsp_pkg::FWGSP_OP_ID_CHECK, 19'h10002, 8'h00);
        rd(fwgsp_pkg::FWGSP_OP_ID_CHECK, 19'h30002, 8'h00);
        rd(fwgsp_pkg::FWGSP_OP_VERIFY, 19'h10000, 8'h00);
        prog(19'h10010, 8'h5A);
        rd(fwgsp_pkg::FWGSP_OP_READ, 19'h10010, 8'h5A);
    endtask
    task automatic t_sleep();
        repeat (10) @(negedge clk_sys_i);
        chk("sleep_hint_o", 8'h01, {7'h00, sleep_hint_o});
        chk("dev_sleep", 8'h01, {7'h00, dev_sleep});
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        t_power_up();
        t_protect();
        t_unprotect();
        t_sleep();
        print_verdict();
    end
    // Watchdog: about three times the expected run
    initial begin
        #(1000 * fwgsp_pkg::CLK_PERIOD_NS);
        errors++;
        $display("Error watchdog expected finish seen timeout");
        print_verdict();
    end
endmodule
